// *** rtl/ep_irq.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - HB iso IN with 2 or 3 transactions: flag error if CPU filled too few banks.
// - HB IN error drives endpoint interrupt only while its enable is one.
// - Iso underflow sets underflow flag; endpoint interrupt if underflow enabled.
// - IN read from empty bank sends zero-length packet, and counts underflow on iso.
// - OUT packet into a full bank is discarded, and counts underflow on iso.
// - Writing one to underflow clear resets the flag.
// - Control OUT stage sets OUT-received; clearing acknowledges and frees bank.
// - OUT endpoint full bank sets flag and bank control; flag clear leaves FIFO.
// - Clearing bank control frees bank, advances, then reflects next bank.
// - OUT-received stays cleared on IN endpoints.
// - Control endpoint IN-sent clear acknowledges and transmits loaded packet.
// - Iso mask layout applies whatever the endpoint type.
// - Toggle-reset set forces DATA0 next packet and self-clears at once.
// - DMA pause bit stops DMA on any endpoint condition until cleared.
// - Ping-pong: old bank DMA finishes, new bank transfer not requested.
// - Pipe enables set by one in set register, cleared by one in clear.
// - HB iso IN short microframe flushes banks.
module ep_irq
	import ep_irq_pkg::*;
#(
	parameter int NUM_BANKS = 2
)(
	// Clock and reset
	input  wire logic        REF_CLK_I,
	input  wire logic        SRST_I,
	// Wishbone slave
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [11:0] ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	// USB link events
	input  wire logic        OUT_PKT_I,
	input  wire logic        IN_TOKEN_I,
	input  wire logic        IN_DONE_I,
	input  wire logic        UFRAME_END_I,
	input  wire logic        CPU_BANK_FILL_I,
	input  wire logic        DMA_BUSY_I,
	// Link actions
	output logic             SEND_ZLP_O,
	output logic             SEND_PKT_O,
	output logic             DROP_OUT_O,
	output logic             FLUSH_O,
	output logic             DATA0_NEXT_O,
	output logic             DMA_REQ_O,
	output logic             EP_IRQ_O,
	output logic             IRQ_O
);

	initial
	begin
		if (NUM_BANKS < 1 || NUM_BANKS > 3)
			$error("NUM_BANKS must be 1..3");
	end

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	logic [31:0] ep_stat, ep_mask, pipe_mask, cfg, irq_stat, irq_mask;
	logic [1:0]  filled, fill_cnt;
	logic        dma_bank_busy;
	logic [31:0] next_ep_stat, next_ep_mask, next_pipe_mask, next_cfg;
	logic [31:0] next_irq_stat, next_irq_mask;
	logic [1:0]  next_filled, next_fill_cnt;
	logic        next_dma_bank_busy;
	logic        next_zlp, next_send, next_drop, next_flush, next_d0;
	logic        next_dma, next_ep_irq, next_irq, next_ack;
	logic [31:0] next_dat;

	logic        wr, rd, is_iso, is_ctrl, is_in, hb, any_cond;
	logic [1:0]  ep_type, nbt;
	logic [31:0] wmask;

	always_comb
	begin
		wmask   = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
		wr      = CYC_I && STB_I && WE_I && !ACK_O;
		rd      = CYC_I && STB_I && !WE_I && !ACK_O;
		ep_type = cfg[CFG_TYPE_LSB +: 2];
		nbt     = cfg[CFG_NBT_LSB +: 2];
		is_iso  = (ep_type == TYPE_ISO);
		is_ctrl = (ep_type == TYPE_CONTROL);
		is_in   = cfg[CFG_DIR_BIT];
		hb      = is_iso && is_in && (nbt >= NBT_MIN_HB);
		next_ep_stat   = ep_stat;
		next_ep_mask   = ep_mask;
		next_pipe_mask = pipe_mask;
		next_cfg       = cfg;
		next_irq_stat  = irq_stat;
		next_irq_mask  = irq_mask;
		next_filled    = filled;
		next_fill_cnt  = fill_cnt;
		next_dma_bank_busy = dma_bank_busy && DMA_BUSY_I;
		next_zlp   = 1'b0;
		next_send  = 1'b0;
		next_drop  = 1'b0;
		next_flush = 1'b0;
		next_d0    = DATA0_NEXT_O;
		next_ack   = CYC_I && STB_I && !ACK_O;
		next_dat   = RESET_WORD;
		// Sent packet ends the old toggle; a set in the same cycle wins
		if (IN_DONE_I)
			next_d0 = 1'b0;
		// Software actions first; hardware sets below win
		if (wr)
		begin
			if (hit(ADR_I, OFS_CONFIG))
				next_cfg = (cfg & ~wmask) | (DAT_I & wmask);
			if (hit(ADR_I, OFS_STAT_CLR))
			begin
				if (DAT_I[BIT_UNDERFLOW])
					next_ep_stat[BIT_UNDERFLOW] = 1'b0;
				if (DAT_I[BIT_HB_IN_ERR])
					next_ep_stat[BIT_HB_IN_ERR] = 1'b0;
				if (DAT_I[BIT_HB_FLUSH])
					next_ep_stat[BIT_HB_FLUSH] = 1'b0;
				if (DAT_I[BIT_OUT_RX])
				begin
					next_ep_stat[BIT_OUT_RX] = 1'b0;
					if (is_ctrl && filled != 2'h0)
						next_filled = filled - 2'h1;
				end
				if (DAT_I[BIT_IN_SENT] && is_ctrl)
				begin
					next_ep_stat[BIT_IN_SENT] = 1'b0;
					next_send = 1'b1;
				end
			end
			if (hit(ADR_I, OFS_MASK_SET))
			begin
				next_ep_mask = ep_mask | (DAT_I & ~(32'h1 << BIT_TOGGLE_RST));
				if (DAT_I[BIT_TOGGLE_RST])
					next_d0 = 1'b1;
			end
			if (hit(ADR_I, OFS_MASK_CLR))
			begin
				next_ep_mask = ep_mask & ~DAT_I;
				// Bank control cleared: release and advance
				if (DAT_I[BIT_BANK_CTRL] && ep_mask[BIT_BANK_CTRL]
					&& filled != 2'h0)
					next_filled = filled - 2'h1;
			end
			if (hit(ADR_I, OFS_PIPE_SET))
				next_pipe_mask = pipe_mask | (DAT_I & PIPE_EN_BITS);
			if (hit(ADR_I, OFS_PIPE_CLR))
				next_pipe_mask = pipe_mask & ~DAT_I;
			if (hit(ADR_I, OFS_IRQ_MASK))
				next_irq_mask = DAT_I;
		end
		// Link events
		if (OUT_PKT_I && !is_in)
		begin
			if (filled == NUM_BANKS[1:0])
			begin
				next_drop = 1'b1;
				if (is_iso)
					next_ep_stat[BIT_UNDERFLOW] = 1'b1;
			end
			else
			begin
				next_filled = next_filled + 2'h1;
				if (!next_dma_bank_busy && !DMA_BUSY_I)
					next_dma_bank_busy = 1'b0;
			end
		end
		if (IN_TOKEN_I && is_in)
		begin
			if (filled == 2'h0)
			begin
				next_zlp = 1'b1;
				if (is_iso)
					next_ep_stat[BIT_UNDERFLOW] = 1'b1;
			end
			else
				next_filled = next_filled - 2'h1;
		end
		if (CPU_BANK_FILL_I && is_in && fill_cnt != 2'h3)
			next_fill_cnt = fill_cnt + 2'h1;
		// CPU filled an IN bank: it is there for the next token
		if (CPU_BANK_FILL_I && is_in && next_filled != NUM_BANKS[1:0])
			next_filled = next_filled + 2'h1;
		if (UFRAME_END_I)
		begin
			next_fill_cnt = 2'h0;
			if (hb && fill_cnt < nbt)
			begin
				next_ep_stat[BIT_HB_IN_ERR] = 1'b1;
				next_ep_stat[BIT_HB_FLUSH]  = 1'b1;
				next_flush  = 1'b1;
				next_filled = 2'h0;
			end
		end
		// Flag and bank control mirror the current bank
		if (is_in)
			next_ep_stat[BIT_OUT_RX] = 1'b0;
		else if (next_filled != filled && next_filled != 2'h0)
		begin
			next_ep_stat[BIT_OUT_RX]    = 1'b1;
			next_ep_mask[BIT_BANK_CTRL] = 1'b1;
		end
		else if (next_filled == 2'h0)
			next_ep_mask[BIT_BANK_CTRL] = 1'b0;
		if (is_in && IN_DONE_I)
			next_ep_stat[BIT_IN_SENT] = 1'b1;
		any_cond = |(next_ep_stat[4:0]);
		next_ep_irq = (next_ep_stat[BIT_HB_IN_ERR] && next_ep_mask[BIT_HB_IN_ERR])
			|| (next_ep_stat[BIT_UNDERFLOW] && next_ep_mask[BIT_UNDERFLOW])
			|| |(next_ep_stat[1:0] & next_ep_mask[1:0])
			|| (next_ep_stat[BIT_HB_FLUSH] && next_ep_mask[BIT_HB_FLUSH]);
		// Old bank finishes; new bank not requested while paused
		if (any_cond && next_ep_mask[BIT_DMA_PAUSE])
			next_dma = dma_bank_busy && DMA_BUSY_I;
		else
			next_dma = next_filled != 2'h0;
		next_dma_bank_busy = next_dma;
		// Sticky device events; set beats read-clear
		if (rd && hit(ADR_I, OFS_IRQ_STAT))
			next_irq_stat = RESET_WORD;
		// Edge of the level, so a read-clear can stick
		if (next_ep_irq && !EP_IRQ_O)
			next_irq_stat[IRQ_EP] = 1'b1;
		if (next_ep_stat[BIT_UNDERFLOW] && !ep_stat[BIT_UNDERFLOW])
			next_irq_stat[IRQ_UF] = 1'b1;
		if (next_ep_stat[BIT_HB_IN_ERR] && !ep_stat[BIT_HB_IN_ERR])
			next_irq_stat[IRQ_HB] = 1'b1;
		next_irq = |(next_irq_stat & next_irq_mask);
		if (rd)
		begin
			case (1'b1)
				hit(ADR_I, OFS_STATUS):    next_dat = ep_stat;
				hit(ADR_I, OFS_MASK):      next_dat = ep_mask;
				hit(ADR_I, OFS_PIPE_MASK): next_dat = pipe_mask;
				hit(ADR_I, OFS_CONFIG):    next_dat = cfg;
				hit(ADR_I, OFS_IRQ_STAT):  next_dat = irq_stat;
				hit(ADR_I, OFS_IRQ_MASK):  next_dat = irq_mask;
				default:                   next_dat = RESET_WORD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge REF_CLK_I)
	begin
		if (SRST_I)
		begin
			ep_stat   <= RESET_WORD;
			ep_mask   <= RESET_WORD;
			pipe_mask <= RESET_WORD;
			cfg       <= RESET_WORD;
			irq_stat  <= RESET_WORD;
			irq_mask  <= RESET_WORD;
			filled    <= 2'h0;
			fill_cnt  <= 2'h0;
			dma_bank_busy <= 1'b0;
			SEND_ZLP_O    <= 1'b0;
			SEND_PKT_O    <= 1'b0;
			DROP_OUT_O    <= 1'b0;
			FLUSH_O       <= 1'b0;
			DATA0_NEXT_O  <= 1'b0;
			DMA_REQ_O     <= 1'b0;
			EP_IRQ_O      <= 1'b0;
			IRQ_O         <= 1'b0;
			ACK_O         <= 1'b0;
			DAT_O         <= RESET_WORD;
		end
		else
		begin
			ep_stat   <= next_ep_stat;
			ep_mask   <= next_ep_mask;
			pipe_mask <= next_pipe_mask;
			cfg       <= next_cfg;
			irq_stat  <= next_irq_stat;
			irq_mask  <= next_irq_mask;
			filled    <= next_filled;
			fill_cnt  <= next_fill_cnt;
			dma_bank_busy <= next_dma_bank_busy;
			SEND_ZLP_O    <= next_zlp;
			SEND_PKT_O    <= next_send;
			DROP_OUT_O    <= next_drop;
			FLUSH_O       <= next_flush;
			DATA0_NEXT_O  <= next_d0;
			DMA_REQ_O     <= next_dma;
			EP_IRQ_O      <= next_ep_irq;
			IRQ_O         <= next_irq;
			ACK_O         <= next_ack;
			DAT_O         <= next_dat;
		end
	end

endmodule : ep_irq

// *** pkg/ep_irq_pkg.sv ***
package ep_irq_pkg;
	// Register word offsets (byte addresses)
	localparam logic [11:0] OFS_STATUS     = 12'h0130;
	localparam logic [11:0] OFS_STAT_CLR   = 12'h0160;
	localparam logic [11:0] OFS_MASK       = 12'h01c0;
	localparam logic [11:0] OFS_MASK_SET   = 12'h01f0;
	localparam logic [11:0] OFS_MASK_CLR   = 12'h0220;
	localparam logic [11:0] OFS_PIPE_MASK  = 12'h0500;
	localparam logic [11:0] OFS_PIPE_SET   = 12'h0530;
	localparam logic [11:0] OFS_PIPE_CLR   = 12'h0560;
	localparam logic [11:0] OFS_CONFIG     = 12'h0100;
	localparam logic [11:0] OFS_IRQ_STAT   = 12'h0600;
	localparam logic [11:0] OFS_IRQ_MASK   = 12'h0604;
	// Endpoint status / mask bit positions
	localparam int BIT_IN_SENT    = 0;
	localparam int BIT_OUT_RX     = 1;
	localparam int BIT_UNDERFLOW  = 2;
	localparam int BIT_HB_IN_ERR  = 3;
	localparam int BIT_HB_FLUSH   = 4;
	localparam int BIT_BANK_CTRL  = 14;
	localparam int BIT_DMA_PAUSE  = 16;
	localparam int BIT_TOGGLE_RST = 18;
	// Pipe enable bits 6:0; bits 5:0 are overflow, nak, error, underflow, out, in
	localparam logic [31:0] PIPE_EN_BITS = 32'h0000_0063 | 32'h0000_001c;
	// Config register fields
	localparam int CFG_TYPE_LSB = 11;
	localparam int CFG_DIR_BIT  = 8;
	localparam int CFG_NBT_LSB  = 13;
	localparam logic [1:0] TYPE_CONTROL = 2'h0;
	localparam logic [1:0] TYPE_ISO     = 2'h1;
	localparam logic [1:0] NBT_MIN_HB   = 2'h2;
	localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
	// Device interrupt status bits
	localparam int IRQ_EP  = 0;
	localparam int IRQ_UF  = 1;
	localparam int IRQ_HB  = 2;
endpackage : ep_irq_pkg

// *** dv/ep_irq_asserts.sv ***
`timescale 1ns/1ps
module ep_irq_asserts
	import ep_irq_pkg::*;
#(
	parameter int NUM_BANKS = 2
)(
	// Clock, reset, bus
	input wire logic        REF_CLK_I,
	input wire logic        SRST_I,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        WE_I,
	input wire logic [11:0] ADR_I,
	input wire logic [3:0]  SEL_I,
	input wire logic [31:0] DAT_I,
	input wire logic [31:0] DAT_O,
	input wire logic        ACK_O,
	// Link side
	input wire logic        OUT_PKT_I,
	input wire logic        IN_TOKEN_I,
	input wire logic        IN_DONE_I,
	input wire logic        UFRAME_END_I,
	input wire logic        CPU_BANK_FILL_I,
	input wire logic        DMA_BUSY_I,
	input wire logic        SEND_ZLP_O,
	input wire logic        SEND_PKT_O,
	input wire logic        DROP_OUT_O,
	input wire logic        FLUSH_O,
	input wire logic        DATA0_NEXT_O,
	input wire logic        DMA_REQ_O,
	input wire logic        EP_IRQ_O,
	input wire logic        IRQ_O
);
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (SRST_I);
	sequence s_take;
		CYC_I && STB_I && !ACK_O;
	endsequence
	sequence s_ack_pulse;
		ACK_O ##1 !ACK_O;
	endsequence
	sequence s_toggle_wr;
		s_take ##0 WE_I && ADR_I == OFS_MASK_SET && DAT_I[BIT_TOGGLE_RST];
	endsequence
	AST_ACK_NEXT: assert property (s_take |=> s_ack_pulse)
		else $error("ack not one cycle after request");
	AST_ACK_CAUSE: assert property (ACK_O |-> $past(CYC_I && STB_I))
		else $error("ack without request");
	AST_NULL_READ: assert property (ACK_O && !WE_I && ADR_I == 12'h0ffc
		|-> DAT_O == 32'h0000_0000) else $error("unmapped read not zero");
	AST_RST_QUIET: assert property ($past(SRST_I) |-> !ACK_O && !EP_IRQ_O
		&& !IRQ_O && !DMA_REQ_O) else $error("output active after reset");
	AST_ZLP_CAUSE: assert property (
		SEND_ZLP_O |-> $past(IN_TOKEN_I)) else $error("zlp without token");
	AST_DROP_CAUSE: assert property (
		DROP_OUT_O |-> $past(OUT_PKT_I)) else $error("drop without packet");
	AST_FLUSH_CAUSE: assert property (
		FLUSH_O |-> $past(UFRAME_END_I)) else $error("flush off frame end");
	AST_PKT_CAUSE: assert property (
		SEND_PKT_O |-> $past(CYC_I && WE_I && ADR_I == OFS_STAT_CLR
		&& DAT_I[BIT_IN_SENT])) else $error("send without clear write");
	AST_TOGGLE_SET: assert property (
		s_toggle_wr |=> ##[0:1] DATA0_NEXT_O) else $error("data0 not set");
	AST_DATA0_FALL: assert property (
		$fell(DATA0_NEXT_O) |-> $past(IN_DONE_I) || $past(SRST_I))
		else $error("data0 lost without a sent packet");
endmodule : ep_irq_asserts

// *** dv/usb_far_end.sv ***
`timescale 1ns/1ps
module usb_far_end (
	// Clock and bench commands
	input  wire logic       clk_i,
	input  wire logic [2:0] cmd_i,
	// Device side
	input  wire logic       zlp_i,
	input  wire logic       pkt_i,
	output logic            out_pkt_o,
	output logic            in_token_o,
	output logic            in_done_o,
	output logic            uframe_end_o
);
	initial {out_pkt_o, in_token_o, in_done_o, uframe_end_o} = 4'h0;
	// Host finishes every packet the device puts on the wire
	always @(posedge clk_i)
	begin
		out_pkt_o    <= cmd_i[0];
		in_token_o   <= cmd_i[1];
		uframe_end_o <= cmd_i[2];
		in_done_o    <= zlp_i | pkt_i;
	end
endmodule : usb_far_end

// *** dv/usb_endpoint_interrupt_status_tb.sv ***
`timescale 1ns/1ps
module usb_endpoint_interrupt_status_tb;
	import ep_irq_pkg::*;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic        clk, srst, cyc, stb, we, ack, op, it, idn, ue, zlp, pkt;
	logic        drop, flush, d0, dreq, epi, irq;
	logic [3:0]  cmd;
	logic [11:0] adr;
	logic [31:0] wd, rdat, v;
	logic [63:0] e;
	logic [63:0] exp_q[$];
	logic [15:0] rnd;
	int          bad_count, compares, cycles, n_zlp, n_pkt, n_flush, i;
	int          n_drop;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input string n, input logic [31:0] x, g);
		compares++;
		if (g !== x)
		begin
			$display("unexpected %s exp %h got %h", n, x, g);
			bad_count++;
		end
	endtask : chk
	task automatic close_out();
		if (bad_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		wd  <= d;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [11:0] a, input logic [31:0] x, m);
		exp_q.push_back({m, x & m});
		wb(1'b0, a, 32'h0);
	endtask : rd
	task automatic pulse(input logic [3:0] b);
		cmd <= b;
		@(posedge clk);
		cmd <= 4'h0;
		repeat (4) @(posedge clk);
	endtask : pulse
	////////////////////////////////////////////////////////////////////////
	ep_irq #(.NUM_BANKS(2)) DUT (.REF_CLK_I(clk), .SRST_I(srst),
		.CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf),
		.DAT_I(wd), .DAT_O(rdat), .ACK_O(ack), .OUT_PKT_I(op),
		.IN_TOKEN_I(it), .IN_DONE_I(idn), .UFRAME_END_I(ue),
		.CPU_BANK_FILL_I(cmd[3]), .DMA_BUSY_I(1'b0), .SEND_ZLP_O(zlp),
		.SEND_PKT_O(pkt), .DROP_OUT_O(drop), .FLUSH_O(flush),
		.DATA0_NEXT_O(d0), .DMA_REQ_O(dreq), .EP_IRQ_O(epi), .IRQ_O(irq));
	usb_far_end far (.clk_i(clk), .cmd_i(cmd[2:0]), .zlp_i(zlp),
		.pkt_i(pkt), .out_pkt_o(op), .in_token_o(it), .in_done_o(idn),
		.uframe_end_o(ue));
	// Read data checked at the ack edge, oldest note first
	always @(posedge clk)
	begin
		cycles++;
		n_zlp += zlp;
		n_pkt += pkt;
		n_flush += flush;
		n_drop += drop;
		if (ack === 1'b1 && we === 1'b0)
		begin
			e = exp_q.pop_front();
			chk("read", e[31:0], rdat & e[63:32]);
		end
		if (cycles == 4000)
		begin
			bad_count++;
			close_out();
		end
	end
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		{srst, cyc, stb, we, cmd, adr, wd, rnd} = {1'b1, 51'h0, 16'h88d9};
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(12'h0ffc, 32'h0, ALL);
		wb(1'b1, 12'h0ffc, ALL);
		rd(OFS_MASK, 32'h0, ALL);
		for (i = 0; i < 4; i++)
		begin
			v = (i == 0) ? ALL : {rnd, rnd};
			wb(1'b1, OFS_PIPE_SET, v);
			rd(OFS_PIPE_MASK, v & PIPE_EN_BITS, ALL);
			wb(1'b1, OFS_PIPE_CLR, v);
			rd(OFS_PIPE_MASK, 32'h0, ALL);
			rnd = lfsr(rnd);
		end
		// Iso IN endpoint, two transactions per microframe
		wb(1'b1, OFS_IRQ_MASK, 32'h7);
		wb(1'b1, OFS_CONFIG, 32'h0000_4900);
		wb(1'b1, OFS_MASK_SET, 32'hc);
		pulse(4'h1);
		pulse(4'h2);
		chk("zlp", 32'h1, n_zlp);
		chk("ep irq", 32'h1, epi);
		rd(OFS_STATUS, 32'h4, 32'h6);
		chk("irq", 32'h1, irq);
		rd(OFS_IRQ_STAT, 32'h2, 32'h2);
		chk("irq", 32'h0, irq);
		wb(1'b1, OFS_STAT_CLR, 32'h4);
		rd(OFS_STATUS, 32'h0, 32'h4);
		chk("ep irq", 32'h0, epi);
		wb(1'b1, OFS_IRQ_MASK, 32'h0);
		pulse(4'h8);
		pulse(4'h8);
		pulse(4'h4);
		rd(OFS_STATUS, 32'h0, 32'h8);
		pulse(4'h8);
		pulse(4'h4);
		rd(OFS_STATUS, 32'h8, 32'h8);
		chk("flush", 32'h1, n_flush);
		chk("ep irq", 32'h1, epi);
		chk("irq", 32'h0, irq);
		rd(OFS_IRQ_STAT, 32'h4, 32'h4);
		wb(1'b1, OFS_MASK_CLR, 32'h8);
		chk("ep irq", 32'h0, epi);
		wb(1'b1, OFS_MASK_SET, 32'h0004_0000);
		chk("data0", 32'h1, d0);
		rd(OFS_MASK, 32'h0, 32'h0004_0000);
		// Control endpoint, then bulk OUT endpoint
		wb(1'b1, OFS_CONFIG, 32'h0);
		wb(1'b1, OFS_STAT_CLR, 32'h1);
		chk("send", 32'h1, n_pkt);
		wb(1'b1, OFS_CONFIG, 32'h0000_1000);
		pulse(4'h1);
		rd(OFS_STATUS, 32'h2, 32'h2);
		wb(1'b1, OFS_STAT_CLR, 32'h2);
		rd(OFS_MASK, 32'h4000, 32'h4000);
		wb(1'b1, OFS_MASK_CLR, 32'h4000);
		rd(OFS_STATUS, 32'h0, 32'h2);
		rd(OFS_MASK, 32'h0, 32'h4000);
		pulse(4'h1);
		pulse(4'h1);
		pulse(4'h1);
		chk("drop", 32'h1, n_drop);
		chk("dma req", 32'h1, dreq);
		wb(1'b1, OFS_MASK_SET, 32'h0001_0000);
		chk("dma req", 32'h0, dreq);
		close_out();
	end
endmodule : usb_endpoint_interrupt_status_tb
bind ep_irq ep_irq_asserts #(.NUM_BANKS(NUM_BANKS)) chk_i (
	.REF_CLK_I, .SRST_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I,
	.DAT_O, .ACK_O, .OUT_PKT_I, .IN_TOKEN_I, .IN_DONE_I, .UFRAME_END_I,
	.CPU_BANK_FILL_I, .DMA_BUSY_I, .SEND_ZLP_O, .SEND_PKT_O, .DROP_OUT_O,
	.FLUSH_O, .DATA0_NEXT_O, .DMA_REQ_O, .EP_IRQ_O, .IRQ_O);
